//--- pkg/fia_pkg.sv
// fia_pkg: constants and types shared by the flash access control block.
// assumes an 8051-style core on one 50 MHz clock with a 14-bit flash address.
package fia_pkg;

    // flash map
    localparam int unsigned FLASH_AW      = 14;
    localparam int unsigned FLASH_DEPTH   = 16384;
    localparam logic [13:0] CFG_LOW_ADDR  = 14'h3ffe;
    localparam logic [13:0] CFG_HIGH_ADDR = 14'h3fff;
    localparam logic [13:0] FREE_LO_ADDR  = 14'h3f00;
    localparam logic [13:0] FREE_HI_ADDR  = 14'h3ffd;
    localparam logic [13:0] LOCK_HI_ADDR  = 14'h01ff;
    localparam logic [13:0] MAIN_LO_ADDR  = 14'h0200;
    localparam logic [13:0] MAIN_HI_ADDR  = 14'h3eff;
    localparam int unsigned LOCK_BIT_POS  = 5;

    // external data map
    localparam logic [15:0] FLASH_XTOP    = 16'h3fff;
    localparam logic [15:0] AUX_BASE      = 16'hfe00;
    localparam int unsigned AUX_DEPTH     = 512;

    // internal data map
    localparam int unsigned INTERNAL_RAM_DEPTH    = 256;
    localparam logic [7:0]  DIRECT_TOP    = 8'h7f;
    localparam logic [7:0]  BIT_BASE      = 8'h20;
    // one bit per sfr row 80h..f8h; rows c0h and e8h are byte-only
    localparam logic [15:0] SFR_BIT_ROWS  = 16'hdeff;

    // special registers and commands
    localparam logic [7:0]  SFR_SOFTWARE_COMMAND     = 8'h97;
    localparam logic [7:0]  SFR_CFG_LOW   = 8'hf7;
    localparam logic [7:0]  CMD_ALL_SET   = 8'h65;
    localparam logic [7:0]  CMD_SOFT_RST  = 8'h56;

    // reset values; lock assumed until the configuration word is loaded
    localparam logic [7:0]  CFG_HIGH_RST  = 8'hff;
    localparam logic [7:0]  CFG_LOW_RST   = 8'h00;
    localparam logic [7:0]  READ_BLOCKED  = 8'h00;

    // flash byte write time
    localparam int unsigned WRITE_TIME_US = 500;
    localparam int unsigned CLK_MHZ       = 50;
    localparam int unsigned WRITE_CYCLES  = WRITE_TIME_US * CLK_MHZ;

    typedef enum logic [2:0] {
        FIA_ST_START,
        FIA_ST_CFG_LO,
        FIA_ST_CFG_HI,
        FIA_ST_CFG_END,
        FIA_ST_IDLE,
        FIA_ST_WRITE
    } fia_state_t;

endpackage : fia_pkg

//--- core/fia_flash_mem.sv
// fia_flash_mem: byte-wide program flash array with two registered read ports.
// assumes writes are paced by the controller; no erase is ever needed.
`timescale 1ns/1ns
module fia_flash_mem #(
    parameter int unsigned DEPTH = fia_pkg::FLASH_DEPTH,
    parameter int unsigned AW    = fia_pkg::FLASH_AW
) (
    input  wire logic          ref_clk_i,
    input  wire logic          wr_en_i,
    input  wire logic [AW-1:0] wr_addr_i,
    input  wire logic [7:0]    wr_data_i,
    input  wire logic [AW-1:0] code_addr_i,
    output logic      [7:0]    code_data_o,
    input  wire logic [AW-1:0] data_addr_i,
    output logic      [7:0]    data_data_o
);

    logic [7:0] mem [DEPTH];

    // plain overwrite of one byte, no page erase first
    always_ff @(posedge ref_clk_i) begin
        if (wr_en_i) begin
            mem[wr_addr_i] <= wr_data_i;
        end
    end

    always_ff @(posedge ref_clk_i) begin
        code_data_o <= mem[code_addr_i];
        data_data_o <= mem[data_addr_i];
    end

endmodule : fia_flash_mem

//--- core/fia_write_timer.sv
// fia_write_timer: counts out the flash byte programming time.
// assumes start_i is a single-cycle pulse given only while idle.
`timescale 1ns/1ns
module fia_write_timer #(
    parameter int unsigned CYCLES = fia_pkg::WRITE_CYCLES
) (
    input  wire logic ref_clk_i,
    input  wire logic resetn_i,
    input  wire logic start_i,
    output logic      busy_o,
    output logic      done_o
);

    localparam int unsigned CW = $clog2(CYCLES + 1);
    localparam logic [CW-1:0] LAST = CW'(CYCLES - 1);

    logic [CW-1:0] count_reg;

    always_ff @(posedge ref_clk_i) begin
        if (!resetn_i) begin
            count_reg <= '0;
            busy_o    <= 1'b0;
            done_o    <= 1'b0;
        end else begin
            done_o <= 1'b0;
            if (start_i && !busy_o) begin
                busy_o    <= 1'b1;
                count_reg <= '0;
            end else if (busy_o) begin
                if (count_reg == LAST) begin
                    busy_o <= 1'b0;
                    done_o <= 1'b1;
                end else begin
                    count_reg <= count_reg + CW'(1);
                end
            end
        end
    end

endmodule : fia_write_timer

//--- core/fia_access_ctrl.sv
// fia_access_ctrl: flash and data memory access control for the cpu core.
// assumes the core issues one-cycle requests and holds off while cpu_wait_o is high.
//
// Functional notes
// - load last two flash bytes at power-on
// - free area 3f00h-3ffdh always open
// - flash writes byte-wise, no erase first
// - after reset only free area is writable
// - low 512 bytes gated by lock and flag
// - main area code-readable, data needs flag
// - 65h sets flag, other values except 56h clear it
// - command register bit 0 reads the flag
// - high config byte never data-accessible
// - low config byte copied to f7h
// - data write starts flash byte write
// - cpu waits for 500 us write
// - peripherals and interrupts keep running meanwhile
// - flash reads add no wait cycles
// - six-wire mode drives port1 bit1 low
// - aux ram at fe00h-ffffh, data path only
// - 256 ram bytes indirect, 128 direct
// - banks at 00h-1fh, bits at 20h-2fh
// - 80h-ffh are sfrs, 14 bit-addressable
// - 56h to command register soft-resets
`timescale 1ns/1ns
module fia_access_ctrl #(
    parameter int unsigned WRITE_CYCLES = fia_pkg::WRITE_CYCLES
) (
    input  wire logic        ref_clk_i,
    input  wire logic        resetn_i,
    input  wire logic        por_i,
    input  wire logic        code_rd_i,
    input  wire logic [13:0] code_addr_i,
    output logic      [7:0]  code_data_o,
    output logic             code_valid_o,
    input  wire logic        xdata_rd_i,
    input  wire logic        xdata_wr_i,
    input  wire logic [15:0] xdata_addr_i,
    input  wire logic [7:0]  xdata_wdata_i,
    output logic      [7:0]  xdata_rdata_o,
    output logic             xdata_ack_o,
    output logic             cpu_wait_o,
    input  wire logic        idata_rd_i,
    input  wire logic        idata_wr_i,
    input  wire logic        idata_indirect_i,
    input  wire logic        idata_bit_i,
    input  wire logic [7:0]  idata_addr_i,
    input  wire logic [7:0]  idata_wdata_i,
    output logic      [7:0]  idata_rdata_o,
    output logic             idata_ack_o,
    output logic             soft_reset_o,
    output logic             all_area_flag_o,
    input  wire logic        prog6_mode_i,
    output logic             port1_bit1_o,
    output logic             port1_bit1_oe_o
);

    // data-path permission per flash sector
    function automatic logic flash_data_ok(input logic [13:0] a, input logic all_area, input logic lock);
        logic ok;
        ok = 1'b0;
        if (a == fia_pkg::CFG_HIGH_ADDR) begin
            ok = 1'b0;
        end else if (a == fia_pkg::CFG_LOW_ADDR) begin
            ok = all_area;
        end else if (a >= fia_pkg::FREE_LO_ADDR && a <= fia_pkg::FREE_HI_ADDR) begin
            ok = 1'b1;
        end else if (a >= fia_pkg::MAIN_LO_ADDR && a <= fia_pkg::MAIN_HI_ADDR) begin
            ok = all_area;
        end else if (a <= fia_pkg::LOCK_HI_ADDR) begin
            ok = !lock && all_area;
        end
        return ok;
    endfunction : flash_data_ok

    function automatic logic code_read_ok(input logic [13:0] a, input logic lock);
        return !(lock && a <= fia_pkg::LOCK_HI_ADDR);
    endfunction : code_read_ok

    fia_pkg::fia_state_t state_reg;
    fia_pkg::fia_state_t state_next;

    logic [7:0]  cfg_high_reg;
    logic [7:0]  cfg_low_reg;
    logic        all_area_reg;
    logic        code_lock;
    logic        idle;

    logic [13:0] wr_addr_reg;
    logic [7:0]  wr_data_reg;
    logic        timer_start;
    logic        timer_busy;
    logic        timer_done;

    logic [13:0] data_port_addr;
    logic [7:0]  flash_code_q;
    logic [7:0]  flash_data_q;

    assign code_lock = cfg_high_reg[fia_pkg::LOCK_BIT_POS];
    assign idle      = (state_reg == fia_pkg::FIA_ST_IDLE);

    // xdata request decode
    logic x_is_flash;
    logic x_is_aux;
    logic x_flash_ok;
    logic x_flash_wr;

    assign x_is_flash = (xdata_addr_i <= fia_pkg::FLASH_XTOP);
    assign x_is_aux   = (xdata_addr_i >= fia_pkg::AUX_BASE);
    assign x_flash_ok = flash_data_ok(xdata_addr_i[13:0], all_area_reg, code_lock);
    assign x_flash_wr = idle && xdata_wr_i && x_is_flash && x_flash_ok;
    assign timer_start = x_flash_wr;

    // the config load borrows the data port while the cpu is still held
    always_comb begin
        data_port_addr = xdata_addr_i[13:0];
        if (state_reg == fia_pkg::FIA_ST_CFG_LO) begin
            data_port_addr = fia_pkg::CFG_LOW_ADDR;
        end else if (state_reg == fia_pkg::FIA_ST_CFG_HI) begin
            data_port_addr = fia_pkg::CFG_HIGH_ADDR;
        end
    end

    fia_flash_mem u_flash (
        .ref_clk_i   (ref_clk_i),
        .wr_en_i     (timer_done && state_reg == fia_pkg::FIA_ST_WRITE),
        .wr_addr_i   (wr_addr_reg),
        .wr_data_i   (wr_data_reg),
        .code_addr_i (code_addr_i),
        .code_data_o (flash_code_q),
        .data_addr_i (data_port_addr),
        .data_data_o (flash_data_q)
    );

    fia_write_timer #(
        .CYCLES (WRITE_CYCLES)
    ) u_timer (
        .ref_clk_i (ref_clk_i),
        .resetn_i  (resetn_i),
        .start_i   (timer_start),
        .busy_o    (timer_busy),
        .done_o    (timer_done)
    );

    always_comb begin
        state_next = state_reg;
        case (state_reg)
            fia_pkg::FIA_ST_START: begin
                state_next = por_i ? fia_pkg::FIA_ST_CFG_LO : fia_pkg::FIA_ST_IDLE;
            end
            fia_pkg::FIA_ST_CFG_LO: begin
                state_next = fia_pkg::FIA_ST_CFG_HI;
            end
            fia_pkg::FIA_ST_CFG_HI: begin
                state_next = fia_pkg::FIA_ST_CFG_END;
            end
            fia_pkg::FIA_ST_CFG_END: begin
                state_next = fia_pkg::FIA_ST_IDLE;
            end
            fia_pkg::FIA_ST_IDLE: begin
                if (x_flash_wr) begin
                    state_next = fia_pkg::FIA_ST_WRITE;
                end
            end
            fia_pkg::FIA_ST_WRITE: begin
                if (timer_done) begin
                    state_next = fia_pkg::FIA_ST_IDLE;
                end
            end
            default: begin
                state_next = fia_pkg::FIA_ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge ref_clk_i) begin
        if (!resetn_i) begin
            state_reg <= fia_pkg::FIA_ST_START;
        end else begin
            state_reg <= state_next;
        end
    end

    // only the core stalls; timers, display and interrupt flags run on
    always_ff @(posedge ref_clk_i) begin
        if (!resetn_i) begin
            cpu_wait_o <= 1'b1;
        end else begin
            cpu_wait_o <= (state_next != fia_pkg::FIA_ST_IDLE);
        end
    end

    always_ff @(posedge ref_clk_i) begin
        if (!resetn_i) begin
            wr_addr_reg <= '0;
            wr_data_reg <= '0;
        end else if (x_flash_wr) begin
            wr_addr_reg <= xdata_addr_i[13:0];
            wr_data_reg <= xdata_wdata_i;
        end
    end

    // config word survives warm resets; only power-on reloads it
    always_ff @(posedge ref_clk_i) begin
        if (!resetn_i) begin
            if (por_i) begin
                cfg_high_reg <= fia_pkg::CFG_HIGH_RST;
            end
        end else if (state_reg == fia_pkg::FIA_ST_CFG_END) begin
            cfg_high_reg <= flash_data_q;
        end
    end

    // internal data decode
    logic       id_is_sfr;
    logic       id_bit_ok;
    logic [7:0] id_byte;
    logic [2:0] id_bitsel;

    always_comb begin
        id_is_sfr = 1'b0;
        id_bit_ok = 1'b1;
        id_byte   = idata_addr_i;
        id_bitsel = idata_addr_i[2:0];
        if (idata_bit_i) begin
            if (!idata_addr_i[7]) begin
                id_byte = fia_pkg::BIT_BASE + {4'h0, idata_addr_i[6:3]};
            end else begin
                id_is_sfr = 1'b1;
                id_byte   = {idata_addr_i[7:3], 3'h0};
                id_bit_ok = fia_pkg::SFR_BIT_ROWS[idata_addr_i[6:3]];
            end
        end else if (!idata_indirect_i && idata_addr_i > fia_pkg::DIRECT_TOP) begin
            id_is_sfr = 1'b1;
        end
    end

    logic sfr_wr;
    assign sfr_wr = idata_wr_i && id_is_sfr && !idata_bit_i;

    always_ff @(posedge ref_clk_i) begin
        if (!resetn_i) begin
            if (por_i) begin
                cfg_low_reg <= fia_pkg::CFG_LOW_RST;
            end
        end else if (state_reg == fia_pkg::FIA_ST_CFG_HI) begin
            cfg_low_reg <= flash_data_q;
        end else if (sfr_wr && id_byte == fia_pkg::SFR_CFG_LOW) begin
            cfg_low_reg <= idata_wdata_i;
        end
    end

    always_ff @(posedge ref_clk_i) begin
        if (!resetn_i) begin
            all_area_reg <= 1'b0;
        end else if (sfr_wr && id_byte == fia_pkg::SFR_SOFTWARE_COMMAND) begin
            if (idata_wdata_i == fia_pkg::CMD_ALL_SET) begin
                all_area_reg <= 1'b1;
            end else if (idata_wdata_i != fia_pkg::CMD_SOFT_RST) begin
                all_area_reg <= 1'b0;
            end
        end
    end

    always_ff @(posedge ref_clk_i) begin
        if (!resetn_i) begin
            soft_reset_o    <= 1'b0;
            all_area_flag_o <= 1'b0;
        end else begin
            soft_reset_o    <= sfr_wr && id_byte == fia_pkg::SFR_SOFTWARE_COMMAND
                               && idata_wdata_i == fia_pkg::CMD_SOFT_RST;
            all_area_flag_o <= all_area_reg;
        end
    end

    // internal ram: whole 256 bytes, banks and bit area included
    logic [7:0] internal_ram [fia_pkg::INTERNAL_RAM_DEPTH];
    logic [7:0] id_q_reg;
    logic       id_pend_reg;
    logic       id_bitop_reg;
    logic [2:0] id_bitsel_reg;

    always_ff @(posedge ref_clk_i) begin
        if (idata_wr_i && !id_is_sfr) begin
            if (idata_bit_i) begin
                internal_ram[id_byte][id_bitsel] <= idata_wdata_i[0];
            end else begin
                internal_ram[id_byte] <= idata_wdata_i;
            end
        end
    end

    always_ff @(posedge ref_clk_i) begin
        if (!resetn_i) begin
            id_q_reg      <= '0;
            id_pend_reg   <= 1'b0;
            id_bitop_reg  <= 1'b0;
            id_bitsel_reg <= '0;
        end else begin
            id_pend_reg   <= idata_rd_i;
            id_bitop_reg  <= idata_bit_i;
            id_bitsel_reg <= id_bitsel;
            if (!id_is_sfr) begin
                id_q_reg <= internal_ram[id_byte];
            end else if (!id_bit_ok || idata_bit_i) begin
                id_q_reg <= '0;
            end else if (id_byte == fia_pkg::SFR_SOFTWARE_COMMAND) begin
                id_q_reg <= {7'h00, all_area_reg};
            end else if (id_byte == fia_pkg::SFR_CFG_LOW) begin
                id_q_reg <= cfg_low_reg;
            end else begin
                id_q_reg <= '0;
            end
        end
    end

    always_ff @(posedge ref_clk_i) begin
        if (!resetn_i) begin
            idata_rdata_o <= '0;
            idata_ack_o   <= 1'b0;
        end else begin
            idata_ack_o <= id_pend_reg;
            if (id_pend_reg) begin
                idata_rdata_o <= id_bitop_reg ? {7'h00, id_q_reg[id_bitsel_reg]} : id_q_reg;
            end
        end
    end

    // aux data ram, reached only from the external data path
    logic [7:0] aux [fia_pkg::AUX_DEPTH];
    logic [7:0] aux_q_reg;

    always_ff @(posedge ref_clk_i) begin
        if (idle && xdata_wr_i && x_is_aux) begin
            aux[xdata_addr_i[8:0]] <= xdata_wdata_i;
        end
        aux_q_reg <= aux[xdata_addr_i[8:0]];
    end

    // reads and refused writes share one fixed two-cycle answer path
    logic x_pend_reg;
    logic x_rd_reg;
    logic x_src_flash_reg;
    logic x_src_aux_reg;
    logic x_ok_reg;

    always_ff @(posedge ref_clk_i) begin
        if (!resetn_i) begin
            x_pend_reg      <= 1'b0;
            x_rd_reg        <= 1'b0;
            x_src_flash_reg <= 1'b0;
            x_src_aux_reg   <= 1'b0;
            x_ok_reg        <= 1'b0;
        end else begin
            x_pend_reg      <= idle && (xdata_rd_i || (xdata_wr_i && !x_flash_wr));
            x_rd_reg        <= xdata_rd_i;
            x_src_flash_reg <= x_is_flash;
            x_src_aux_reg   <= x_is_aux;
            x_ok_reg        <= x_flash_ok;
        end
    end

    always_ff @(posedge ref_clk_i) begin
        if (!resetn_i) begin
            xdata_rdata_o <= '0;
            xdata_ack_o   <= 1'b0;
        end else begin
            xdata_ack_o <= x_pend_reg || (timer_done && state_reg == fia_pkg::FIA_ST_WRITE);
            if (x_pend_reg && x_rd_reg) begin
                if (x_src_flash_reg) begin
                    xdata_rdata_o <= x_ok_reg ? flash_data_q : fia_pkg::READ_BLOCKED;
                end else if (x_src_aux_reg) begin
                    xdata_rdata_o <= aux_q_reg;
                end else begin
                    xdata_rdata_o <= fia_pkg::READ_BLOCKED;
                end
            end
        end
    end

    // code fetch path, no stall inserted
    logic code_pend_reg;
    logic code_ok_reg;

    always_ff @(posedge ref_clk_i) begin
        if (!resetn_i) begin
            code_pend_reg <= 1'b0;
            code_ok_reg   <= 1'b0;
            code_data_o   <= '0;
            code_valid_o  <= 1'b0;
        end else begin
            code_pend_reg <= code_rd_i;
            code_ok_reg   <= code_read_ok(code_addr_i, code_lock);
            code_valid_o  <= code_pend_reg;
            if (code_pend_reg) begin
                code_data_o <= code_ok_reg ? flash_code_q : fia_pkg::READ_BLOCKED;
            end
        end
    end

    // programming mode strap arrives from a pin
    logic p6_meta_reg;
    logic p6_sync_reg;

    always_ff @(posedge ref_clk_i) begin
        if (!resetn_i) begin
            p6_meta_reg     <= 1'b0;
            p6_sync_reg     <= 1'b0;
            port1_bit1_o    <= 1'b0;
            port1_bit1_oe_o <= 1'b0;
        end else begin
            p6_meta_reg     <= prog6_mode_i;
            p6_sync_reg     <= p6_meta_reg;
            port1_bit1_o    <= 1'b0;
            port1_bit1_oe_o <= p6_sync_reg;
        end
    end

endmodule : fia_access_ctrl

//--- test/fia_cpu_model.sv
// fia_cpu_model: movx side of the cpu core, one request at a time.
// assumes the bench holds wr_i, addr_i and dat_i until busy_o drops.
`timescale 1ns/1ns
module fia_cpu_model (
    input  wire logic        ref_clk_i,
    input  wire logic        go_i,
    input  wire logic        wr_i,
    input  wire logic [15:0] addr_i,
    input  wire logic [7:0]  dat_i,
    input  wire logic        cpu_wait_i,
    input  wire logic        ack_i,
    output logic             xdata_rd_o = 1'b0,
    output logic             xdata_wr_o = 1'b0,
    output logic      [15:0] xdata_addr_o = 16'h0000,
    output logic      [7:0]  xdata_wdata_o = 8'h00,
    output logic             busy_o = 1'b0
);
    logic pend_reg = 1'b0;
    // clock slowed and supply kept high by software before writes
    always @(posedge ref_clk_i) begin
        xdata_rd_o <= 1'b0;
        xdata_wr_o <= 1'b0;
        if (go_i) begin
            pend_reg <= 1'b1;
            busy_o   <= 1'b1;
        end else if (pend_reg && !cpu_wait_i) begin
            pend_reg      <= 1'b0;
            xdata_rd_o    <= !wr_i;
            xdata_wr_o    <= wr_i;
            xdata_addr_o  <= addr_i;
            xdata_wdata_o <= dat_i;
        end else if (ack_i && busy_o && !pend_reg) begin
            busy_o        <= 1'b0;
            // flip released lines so a stale value cannot pass
            xdata_addr_o  <= ~xdata_addr_o;
            xdata_wdata_o <= ~xdata_wdata_o;
        end
    end
endmodule : fia_cpu_model

//--- test/fia_access_ctrl_asserts.sv
// fia_access_ctrl_chk: port-level checks of the flash access block.
// assumes one clock; bound to every fia_access_ctrl instance.
`timescale 1ns/1ns
module fia_access_ctrl_chk #(
    parameter int unsigned WRITE_CYCLES = 20
) (
    input wire logic        ref_clk_i,
    input wire logic        resetn_i,
    input wire logic        xdata_rd_i,
    input wire logic        xdata_wr_i,
    input wire logic [15:0] xdata_addr_i,
    input wire logic        xdata_ack_o,
    input wire logic        cpu_wait_o,
    input wire logic        idata_wr_i,
    input wire logic        idata_indirect_i,
    input wire logic        idata_bit_i,
    input wire logic [7:0]  idata_addr_i,
    input wire logic [7:0]  idata_wdata_i,
    input wire logic        soft_reset_o,
    input wire logic        all_area_flag_o
);
    default clocking @(posedge ref_clk_i); endclocking
    default disable iff (!resetn_i);
    logic [15:0] wcnt_reg;
    wire dw = idata_wr_i && !idata_indirect_i && !idata_bit_i && idata_addr_i == 8'h97;
    wire xw = xdata_wr_i && !cpu_wait_o;
    always_ff @(posedge ref_clk_i) begin
        if (!resetn_i || !cpu_wait_o)
            wcnt_reg <= 16'h0000;
        else
            wcnt_reg <= wcnt_reg + 16'h0001;
    end
    property p_xrd; xdata_rd_i && !cpu_wait_o |-> ##2 xdata_ack_o && !cpu_wait_o; endproperty
    a_xrd: assert property (p_xrd) else $error("xdata read answer late or stalled");
    property p_set; dw && idata_wdata_i == 8'h65 |-> ##2 all_area_flag_o; endproperty
    a_set: assert property (p_set) else $error("flag not set");
    property p_clr; dw && idata_wdata_i != 8'h65 && idata_wdata_i != 8'h56 |-> ##2 !all_area_flag_o; endproperty
    a_clr: assert property (p_clr) else $error("flag not cleared");
    property p_srst; dw && idata_wdata_i == 8'h56 |=> soft_reset_o ##1 !soft_reset_o; endproperty
    a_srst: assert property (p_srst) else $error("soft reset pulse wrong");
    property p_free; xw && xdata_addr_i >= 16'h3f00 && xdata_addr_i <= 16'h3ffd |=> cpu_wait_o; endproperty
    a_free: assert property (p_free) else $error("free area write refused");
    property p_cfgh; xw && xdata_addr_i == 16'h3fff |=> !cpu_wait_o ##1 xdata_ack_o; endproperty
    a_cfgh: assert property (p_cfgh) else $error("high config byte written");
    property p_main; xw && xdata_addr_i >= 16'h0200 && xdata_addr_i <= 16'h3eff |=> cpu_wait_o == all_area_flag_o; endproperty
    a_main: assert property (p_main) else $error("main area gate wrong");
    // the counter also sees the edge that drops the wait, hence one more than the write time
    property p_wlen; $fell(cpu_wait_o) && xdata_ack_o |-> wcnt_reg == WRITE_CYCLES + 1; endproperty
    a_wlen: assert property (p_wlen) else $error("flash write stall length wrong");
    c_write: cover property (xw ##1 cpu_wait_o);
    c_srst: cover property (soft_reset_o);
    c_done: cover property ($fell(cpu_wait_o) && xdata_ack_o);
endmodule : fia_access_ctrl_chk
bind fia_access_ctrl fia_access_ctrl_chk #(.WRITE_CYCLES(WRITE_CYCLES)) chk_u (.*);

//--- test/testbench.sv
// testbench: drives the flash access block from the cpu side.
// assumes a 20-cycle write time; flash starts unknown, so lock cases are skipped.
`timescale 1ns/1ns
module testbench;
    localparam int unsigned WC = 20;
    logic        ref_clk_i = 1'b0, resetn_i = 1'b0, por_i = 1'b1, code_rd_i = 1'b0;
    logic [13:0] code_addr_i = 14'h0000;
    logic [7:0]  code_data_o, xdata_rdata_o, idata_rdata_o, xdata_wdata_i, xd = 8'h00;
    logic        code_valid_o, xdata_ack_o, cpu_wait_o, idata_ack_o, xdata_rd_i, xdata_wr_i;
    logic [15:0] xdata_addr_i, xa = 16'h0000;
    logic        idata_rd_i = 1'b0, idata_wr_i = 1'b0, idata_indirect_i = 1'b0, idata_bit_i = 1'b0;
    logic [7:0]  idata_addr_i = 8'h00, idata_wdata_i = 8'h00;
    logic        soft_reset_o, all_area_flag_o, prog6_mode_i = 1'b0, port1_bit1_o, port1_bit1_oe_o;
    logic        go = 1'b0, wr = 1'b0, busy;
    int          failures = 0, num_checks = 0, cyc = 0, wcyc = 0, srst = 0;
    fia_access_ctrl #(.WRITE_CYCLES(WC)) dut_u (.*);
    fia_cpu_model cpu_u (.ref_clk_i, .go_i(go), .wr_i(wr), .addr_i(xa), .dat_i(xd), .cpu_wait_i(cpu_wait_o),
        .ack_i(xdata_ack_o), .xdata_rd_o(xdata_rd_i), .xdata_wr_o(xdata_wr_i), .xdata_addr_o(xdata_addr_i),
        .xdata_wdata_o(xdata_wdata_i), .busy_o(busy));
    initial forever #10 ref_clk_i = ~ref_clk_i;
    always @(posedge ref_clk_i) begin
        cyc++;
        if (cpu_wait_o === 1'b1) wcyc++;
        if (soft_reset_o === 1'b1) srst++;
        if (cyc == 20000) begin
            failures++;
            final_report();
        end
    end
    task automatic final_report();
        $display("checks %0d failures %0d", num_checks, failures);
        if (failures == 0 && num_checks > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask : final_report
    task automatic chk(input logic ok, input string m);
        num_checks++;
        if (ok !== 1'b1) begin
            failures++;
            $display("unexpected at %0t: %s", $time, m);
        end
    endtask : chk
    task automatic tk(input int n);
        repeat (n) @(posedge ref_clk_i);
    endtask : tk
    task automatic rst(input logic p);
        resetn_i <= 1'b0;
        por_i <= p;
        tk(4);
        resetn_i <= 1'b1;
        tk(6);
    endtask : rst
    // one movx access; n is the expected write time in cycles, 0 when the access must not stall
    task automatic xs(input logic w, input logic [15:0] a, input logic [7:0] d, input logic [7:0] e, input int n);
        int k;
        go <= 1'b1;
        wr <= w;
        xa <= a;
        xd <= d;
        wcyc = 0;
        tk(1);
        go <= 1'b0;
        k = 0;
        do begin
            tk(1);
            k++;
        end while (busy !== 1'b0 && k < 100);
        chk(k < 100 && wcyc == (n == 0 ? 0 : n + 1), "xdata stall"); // release edge still sees wait high
        if (!w) chk(xdata_rdata_o === e, "xdata read");
    endtask : xs
    task automatic ia(input logic w, input logic i, input logic b, input logic [7:0] a, input logic [7:0] d,
                      input logic [7:0] e);
        idata_rd_i <= !w;
        idata_wr_i <= w;
        idata_indirect_i <= i;
        idata_bit_i <= b;
        idata_addr_i <= a;
        idata_wdata_i <= d;
        tk(1);
        idata_rd_i <= 1'b0;
        idata_wr_i <= 1'b0;
        tk(1);
        #1;
        if (!w) chk(idata_ack_o === 1'b1 && idata_rdata_o === e, "idata read");
        tk(2);
    endtask : ia
    task automatic cr(input logic [13:0] a, input logic [7:0] e);
        code_rd_i <= 1'b1;
        code_addr_i <= a;
        tk(1);
        code_rd_i <= 1'b0;
        tk(1);
        #1;
        chk(code_valid_o === 1'b1 && code_data_o === e, "code read");
        tk(2);
    endtask : cr
    task automatic t_free();
        xs(1, 16'h3f00, 8'h5a, 8'h00, WC);
        xs(0, 16'h3f00, 8'h00, 8'h5a, 0);
        cr(14'h3f00, 8'h5a);
        xs(1, 16'h3f00, 8'h3c, 8'h00, WC);
        xs(1, 16'h3ffd, 8'ha5, 8'h00, WC);
        xs(0, 16'h3f00, 8'h00, 8'h3c, 0);
        cr(14'h3ffd, 8'ha5);
    endtask : t_free
    task automatic t_flag();
        ia(0, 0, 0, 8'h97, 8'h00, 8'h00);
        xs(1, 16'h3eff, 8'h77, 8'h00, 0);
        xs(0, 16'h3eff, 8'h00, 8'h00, 0);
        ia(1, 0, 0, 8'h97, 8'h65, 8'h00);
        ia(0, 0, 0, 8'h97, 8'h00, 8'h01);
        xs(1, 16'h3eff, 8'h77, 8'h00, WC);
        xs(0, 16'h3eff, 8'h00, 8'h77, 0);
        xs(1, 16'h3ffe, 8'h11, 8'h00, WC);
        xs(1, 16'h3fff, 8'h22, 8'h00, 0);
        ia(1, 0, 0, 8'h97, 8'h12, 8'h00);
        xs(0, 16'h3ffe, 8'h00, 8'h00, 0);
    endtask : t_flag
    task automatic t_mem();
        xs(1, 16'hfe00, 8'h81, 8'h00, 0);
        xs(1, 16'hffff, 8'h42, 8'h00, 0);
        xs(0, 16'hfe00, 8'h00, 8'h81, 0);
        xs(0, 16'hffff, 8'h00, 8'h42, 0);
        xs(0, 16'h4000, 8'h00, 8'h00, 0);
        ia(1, 1, 0, 8'h90, 8'h6e, 8'h00);
        ia(0, 1, 0, 8'h90, 8'h00, 8'h6e);
        ia(0, 0, 0, 8'h90, 8'h00, 8'h00);
        ia(1, 0, 0, 8'h20, 8'h00, 8'h00);
        ia(1, 0, 1, 8'h03, 8'h01, 8'h00);
        ia(0, 0, 0, 8'h20, 8'h00, 8'h08);
        prog6_mode_i <= 1'b1;
        tk(6);
        chk(port1_bit1_oe_o === 1'b1 && port1_bit1_o === 1'b0, "port1 bit1");
        prog6_mode_i <= 1'b0;
    endtask : t_mem
    task automatic t_rst();
        ia(1, 0, 0, 8'h97, 8'h65, 8'h00);
        srst = 0;
        ia(1, 0, 0, 8'h97, 8'h56, 8'h00);
        chk(srst == 1, "soft reset pulse");
        ia(0, 0, 0, 8'h97, 8'h00, 8'h01);
        rst(1'b0);
        ia(0, 0, 0, 8'h97, 8'h00, 8'h00);
        rst(1'b1);
        ia(0, 0, 0, 8'hf7, 8'h00, 8'h11);
        ia(1, 0, 0, 8'hf7, 8'h33, 8'h00);
        ia(0, 0, 0, 8'hf7, 8'h00, 8'h33);
    endtask : t_rst
    initial begin
        rst(1'b1);
        t_free();
        t_flag();
        t_mem();
        t_rst();
        final_report();
    end
endmodule : testbench
